// file: clock_consumer_model.sv
`timescale 1ns/1ps
`default_nettype none
// cpu, flash and io side: advances only on enables, so the gap is the factor
module clock_consumer_model (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        systemClockEnable,
   input wire logic        clockOutputPin,
   output var logic [9:0]  gap,
   output var logic [15:0] pinRises
);
   logic [9:0] since;
   logic       pinLast;
   initial begin
      since = 10'h001;
      gap = 10'h000;
      pinRises = 16'h0000;
      pinLast = 1'b0;
   end
   // pin rises counted even in reset, since the pin keeps running there
   always @(posedge mclk) begin
      pinLast <= clockOutputPin;
      if (clockOutputPin && !pinLast) begin
         pinRises <= pinRises + 16'h0001;
      end
      if (rst || systemClockEnable) begin
         gap <= rst ? gap : since;
         since <= 10'h001;
      end else begin
         since <= since + 10'h001;
      end
   end
endmodule
`default_nettype wire

// file: system_clock_map.vh
`ifndef SYSTEM_CLOCK_MAP_VH
`define SYSTEM_CLOCK_MAP_VH

// register offsets on the plain register port
`define PLL_CTRL_ADDR        8'h49
`define DIV_CTRL_ADDR        8'h61
`define TRIM_ADDR            8'h66

// divider control fields
`define DIV_CE_BIT           7
`define DIV_UNLOCK_VALUE     8'h80
`define DIV_SEL_RESET        4'h0
`define DIV_SEL_RESET_DIV8   4'h3
`define DIV_SEL_MAX          4'h8
`define UNLOCK_WINDOW_CK     3'h4

// pll control fields
`define PLL_FACTOR_BIT       2
`define PLL_ENABLE_BIT       1
`define PLL_LOCK_BIT         0
`define PLL_CTRL_RESET       8'h00

// clock source fuse codes
`define SRC_EXT_CLOCK        4'h0
`define SRC_PLL_EXT_CLK      4'h1
`define SRC_RC_OSC           4'h2
`define SRC_PLL_RC           4'h3
`define SRC_PLL_EXT_OSC      4'h5

// start-up fuse codes
`define SUT_BOD              2'h0
`define SUT_FAST             2'h1
`define SUT_SLOW             2'h2

// timing
`define MCLK_PERIOD_NS       100
`define MCLK_FREQ_HZ         10000000
`define WDT_FREQ_HZ          128000
`define STARTUP_BASE_CK      20'h0000E
`define WAKE_CK              20'h00006
`define FAST_DELAY_US        4100
`define SLOW_DELAY_US        65000
`define PLL_LOCK_US          100000

`endif

// file: system_clock_prescaler_pll_ctrl.v
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

`include "system_clock_map.vh"

// Functional notes
// - watchdog tick from fixed 128 kHz source
// - fuse code 0000 runs from external clock
// - wake 6 CK, reset 14 CK plus delay
// - clock output fuse drives pin, even in reset
// - output pin carries the divided clock; divide-by-1 gives a steady high
// - cpu, flash and io divided together
// - division changes only at period boundaries
// - new factor active after old plus new period
// - change enable set only by exact 0x80
// - change enable clears after four cycles
// - rewriting unlock neither extends nor clears window
// - reset loads factory trim, software may rewrite
// - trim bit 7 picks the frequency range
// - low seven trim bits tune within range
// - pll factor bit picks 64 or 32 MHz
// - pll enable starts pll and rc oscillator
// - lock flag set after lock time
// - select codes 0 to 8 give 1 to 256
// - reset select follows divide-by-eight fuse
module system_clock_prescaler_pll_ctrl #(
   parameter [19:0] FAST_DELAY_CYCLES =
      (`FAST_DELAY_US * 1000 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS,
   parameter [19:0] SLOW_DELAY_CYCLES =
      (`SLOW_DELAY_US * 1000 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS,
   parameter [19:0] PLL_LOCK_CYCLES   =
      (`PLL_LOCK_US * 1000 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS
) (
   input  wire       mclk,
   input  wire       rst,
   input  wire [7:0] address,
   input  wire [7:0] writeData,
   input  wire       writeStrobe,
   input  wire       readStrobe,
   output reg  [7:0] readData,
   input  wire [3:0] clockSourceSelectFuses,
   input  wire [1:0] startupTimeFuses,
   input  wire       clockOutputFuse,
   input  wire       divideByEightFuse,
   input  wire [7:0] factoryTrim,
   input  wire       powerDownEnter,
   input  wire       wakeEvent,
   output reg        systemClockEnable,
   output reg        coreRunning,
   output reg        clockOutputPin,
   output reg        clockOutputEnable,
   output reg        externalClockSelected,
   output reg  [7:0] rcOscillatorTrim,
   output reg        rcOscillatorRunning,
   output reg        pllRunning,
   output reg        pllFactorSelect,
   output reg        pllLockedFlag,
   output reg        watchdogTick
);

   // start-up sequencer states
   localparam [2:0] ST_DELAY = 3'h0;
   localparam [2:0] ST_RUN   = 3'h1;
   localparam [2:0] ST_SLEEP = 3'h2;
   localparam [2:0] ST_WAKE  = 3'h3;

   // watchdog divider end count, rounded down
   localparam integer WDT_DIV  = `MCLK_FREQ_HZ / `WDT_FREQ_HZ;
   localparam [6:0]   WDT_LAST = WDT_DIV[6:0] - 7'h01;

   // last count of one divided period; reserved codes fall back to 256
   function [7:0] periodMax;
      input [3:0] sel;
      reg   [8:0] span;
      begin
         // one bit wider so the 256 factor fits before the cut
         span = (9'h001 << sel) - 9'h001;
         if (sel > `DIV_SEL_MAX) begin
            periodMax = 8'hFF;
         end else begin
            periodMax = span[7:0];
         end
      end
   endfunction

   // lowest count that still holds the output high; below it the second half is low
   function [7:0] halfMark;
      input [3:0] sel;
      reg   [7:0] pm;
      begin
         pm = periodMax(sel);
         halfMark = {1'b0, pm[7:1]} + {7'h00, pm[0]};
      end
   endfunction

   // fuse codes that make the pll the system clock
   function pllIsSource;
      input [3:0] code;
      begin
         pllIsSource = (code == `SRC_PLL_RC) || (code == `SRC_PLL_EXT_OSC) ||
                       (code == `SRC_PLL_EXT_CLK);
      end
   endfunction

   // fuse synchronisers; fuses are static, but still come from outside
   reg  [15:0] fuseMeta;
   reg  [15:0] fuseSync;
   wire [7:0]  trimFuse     = fuseSync[15:8];
   wire [3:0]  ckselFuse    = fuseSync[7:4];
   wire [1:0]  sutFuse      = fuseSync[3:2];
   wire        ckoutFuse    = fuseSync[1];
   wire        div8Fuse     = fuseSync[0];

   always @(posedge mclk) begin
      fuseMeta <= {factoryTrim, clockSourceSelectFuses, startupTimeFuses,
                   clockOutputFuse, divideByEightFuse};
      fuseSync <= fuseMeta;
   end

   // reset age; the divider waits until the fuse sync has settled
   reg [2:0] rstPipe;

   always @(posedge mclk) begin
      rstPipe <= {rstPipe[1:0], rst};
   end

   wire [3:0] resetSel = div8Fuse ? `DIV_SEL_RESET_DIV8 : `DIV_SEL_RESET;

   // bus decode
   wire wrDiv  = writeStrobe && (address == `DIV_CTRL_ADDR);
   wire wrPll  = writeStrobe && (address == `PLL_CTRL_ADDR);
   wire wrTrim = writeStrobe && (address == `TRIM_ADDR);

   // divider select register with timed unlock
   reg [3:0] divSel;
   reg       changeEnable;
   reg [2:0] window;

   always @(posedge mclk) begin
      if (rst) begin
         divSel       <= resetSel;
         changeEnable <= 1'b0;
         window       <= 3'h0;
      end else begin
         // timeout runs regardless of rewrites, so it cannot be stretched
         if (changeEnable) begin
            window <= window - 3'h1;
            if (window == 3'h1) begin
               changeEnable <= 1'b0;
            end
         end
         if (wrDiv && (writeData == `DIV_UNLOCK_VALUE)) begin
            if (!changeEnable) begin
               changeEnable <= 1'b1;
               window       <= `UNLOCK_WINDOW_CK;
            end
         end else if (wrDiv && changeEnable && !writeData[`DIV_CE_BIT]) begin
            divSel       <= writeData[3:0];
            changeEnable <= 1'b0;
            window       <= 3'h0;
         end
      end
   end

   // prescaler counter; a new factor is picked up only when the
   // current period ends, so no short or fast period can appear
   reg  [3:0] activeSel;
   reg  [7:0] divCount;
   reg  [3:0] next_activeSel;
   reg  [7:0] next_divCount;

   always @* begin
      next_activeSel = activeSel;
      next_divCount  = divCount - 8'h01;
      if (divCount == 8'h00) begin
         next_activeSel = rst ? resetSel : divSel;
         next_divCount  = periodMax(next_activeSel);
      end
   end

   // run-or-hold form: an unknown reset age at power-up falls to the hold branch
   always @(posedge mclk) begin
      if (!rst || rstPipe[2]) begin
         activeSel <= next_activeSel;
         divCount  <= next_divCount;
      end else begin
         activeSel <= resetSel;
         divCount  <= 8'h00;
      end
   end

   // start-up and wake sequencing
   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [19:0] seqCount;
   reg  [19:0] next_seqCount;
   reg  [19:0] resetDelay;

   // additional reset delay by start-up fuses; reserved code takes the longest
   always @* begin
      case (sutFuse)
         `SUT_BOD:  resetDelay = `STARTUP_BASE_CK;
         `SUT_FAST: resetDelay = `STARTUP_BASE_CK + FAST_DELAY_CYCLES;
         `SUT_SLOW: resetDelay = `STARTUP_BASE_CK + SLOW_DELAY_CYCLES;
         default:   resetDelay = `STARTUP_BASE_CK + SLOW_DELAY_CYCLES;
      endcase
   end

   always @* begin
      next_state    = state;
      next_seqCount = seqCount + 20'h00001;
      case (state)
         ST_DELAY: begin
            if (seqCount >= resetDelay - 20'h00001) begin
               next_state    = ST_RUN;
               next_seqCount = 20'h00000;
            end
         end
         ST_RUN: begin
            next_seqCount = 20'h00000;
            if (powerDownEnter) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            next_seqCount = 20'h00000;
            if (wakeEvent) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (seqCount >= `WAKE_CK - 20'h00001) begin
               next_state    = ST_RUN;
               next_seqCount = 20'h00000;
            end
         end
         default: begin
            next_state    = ST_DELAY;
            next_seqCount = 20'h00000;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (rst) begin
         state    <= ST_DELAY;
         seqCount <= 20'h00000;
      end else begin
         state    <= next_state;
         seqCount <= next_seqCount;
      end
   end

   // one shared enable for cpu, flash and io keeps them in step
   always @(posedge mclk) begin
      if (rst) begin
         systemClockEnable <= 1'b0;
         coreRunning       <= 1'b0;
      end else begin
         systemClockEnable <= (next_divCount == 8'h00) && (next_state == ST_RUN);
         coreRunning       <= (next_state == ST_RUN);
      end
   end

   // clock output pin runs in reset too; divide-by-1 shows a steady high
   always @(posedge mclk) begin
      clockOutputEnable <= ckoutFuse;
      if (ckoutFuse) begin
         clockOutputPin <= (next_divCount >= halfMark(next_activeSel));
      end else begin
         clockOutputPin <= 1'b0;
      end
   end

   // source status
   always @(posedge mclk) begin
      if (rst) begin
         externalClockSelected <= 1'b0;
      end else begin
         externalClockSelected <= (ckselFuse == `SRC_EXT_CLOCK);
      end
   end

   // rc trim: bit 7 range, bits 6:0 tune, driven straight to the oscillator
   always @(posedge mclk) begin
      if (rst) begin
         rcOscillatorTrim <= trimFuse;
      end else if (wrTrim) begin
         rcOscillatorTrim <= writeData;
      end
   end

   // pll control; the enable reads one while the pll is the source
   reg        pllEnableBit;
   reg [19:0] lockCount;
   wire       pllOn = pllEnableBit || pllIsSource(ckselFuse);

   always @(posedge mclk) begin
      if (rst) begin
         pllEnableBit    <= |(`PLL_CTRL_RESET & (8'h01 << `PLL_ENABLE_BIT));
         pllFactorSelect <= |(`PLL_CTRL_RESET & (8'h01 << `PLL_FACTOR_BIT));
      end else if (wrPll) begin
         pllEnableBit    <= writeData[`PLL_ENABLE_BIT];
         pllFactorSelect <= writeData[`PLL_FACTOR_BIT];
      end
   end

   // lock timer restarts whenever the pll is switched off
   always @(posedge mclk) begin
      if (rst || !pllOn) begin
         lockCount     <= 20'h00000;
         pllLockedFlag <= 1'b0;
      end else if (lockCount >= PLL_LOCK_CYCLES - 20'h00001) begin
         pllLockedFlag <= 1'b1;
      end else begin
         lockCount <= lockCount + 20'h00001;
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         pllRunning          <= 1'b0;
         rcOscillatorRunning <= 1'b0;
      end else begin
         pllRunning          <= pllOn;
         rcOscillatorRunning <= pllOn || (ckselFuse == `SRC_RC_OSC);
      end
   end

   // watchdog tick; counts the undivided clock so the prescaler never
   // slows it; a real part has its own oscillator here
   reg [6:0] wdtCount;

   always @(posedge mclk) begin
      if (rst) begin
         wdtCount     <= 7'h00;
         watchdogTick <= 1'b0;
      end else if (wdtCount == WDT_LAST) begin
         wdtCount     <= 7'h00;
         watchdogTick <= 1'b1;
      end else begin
         wdtCount     <= wdtCount + 7'h01;
         watchdogTick <= 1'b0;
      end
   end

   // read port, data one cycle after the strobe; unmapped reads zero
   always @(posedge mclk) begin
      if (rst) begin
         readData <= 8'h00;
      end else if (readStrobe) begin
         case (address)
            `DIV_CTRL_ADDR: readData <= {changeEnable, 3'h0, divSel};
            `TRIM_ADDR:     readData <= rcOscillatorTrim;
            `PLL_CTRL_ADDR: readData <= {5'h00, pllFactorSelect, pllOn,
                                         pllLockedFlag};
            default:        readData <= 8'h00;
         endcase
      end else begin
         readData <= 8'h00;
      end
   end

endmodule

`default_nettype wire

// file: system_clock_props.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the clock block, all in the mclk domain
module system_clock_props #(
   parameter [19:0] PLL_LOCK_CYCLES = 20'h0001E
) (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [7:0] address,
   input wire logic [7:0] writeData,
   input wire logic       writeStrobe,
   input wire logic       readStrobe,
   input wire logic [7:0] readData,
   input wire logic [3:0] clockSourceSelectFuses,
   input wire logic       powerDownEnter,
   input wire logic       wakeEvent,
   input wire logic       systemClockEnable,
   input wire logic       coreRunning,
   input wire logic       externalClockSelected,
   input wire logic [7:0] rcOscillatorTrim,
   input wire logic       rcOscillatorRunning,
   input wire logic       pllRunning,
   input wire logic       pllFactorSelect,
   input wire logic       pllLockedFlag,
   input wire logic       watchdogTick
);
   logic [19:0] onCount;
   // run length of the pll, saturating so a long run never wraps
   always @(posedge mclk) begin
      if (rst || !pllRunning) begin
         onCount <= 20'h00000;
      end else if (onCount != 20'hFFFFF) begin
         onCount <= onCount + 20'h00001;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence trimWrite;
      writeStrobe && address == 8'h66;
   endsequence
   sequence pllWrite;
      writeStrobe && address == 8'h49;
   endsequence
   sequence wakeWait;
      !coreRunning [*5] ##[1:2] coreRunning;
   endsequence
   chk_read_idle: assert property (!readStrobe |=> readData == 8'h00)
      else $error("read data not zero outside read answer");
   chk_trim_read: assert property (readStrobe && address == 8'h66 |=> readData == rcOscillatorTrim)
      else $error("trim read back wrong");
   chk_trim_write: assert property (trimWrite |=> rcOscillatorTrim == $past(writeData))
      else $error("trim write lost");
   chk_wdt_period: assert property (watchdogTick |=> !watchdogTick ##77 watchdogTick)
      else $error("watchdog tick spacing wrong");
   chk_ext_select: assert property (!$past(rst) && !$past(rst, 2)
      |-> externalClockSelected == (clockSourceSelectFuses == 4'h0))
      else $error("external source flag wrong");
   chk_pll_start: assert property (pllWrite ##0 writeData[1] |-> ##2 (pllRunning && rcOscillatorRunning))
      else $error("pll or reference not started");
   chk_pll_factor: assert property (pllWrite |=> pllFactorSelect == $past(writeData[2]))
      else $error("pll factor not taken");
   chk_lock_time: assert property ($rose(pllLockedFlag)
      |-> onCount + 20'h00002 >= PLL_LOCK_CYCLES && onCount <= PLL_LOCK_CYCLES + 20'h00002)
      else $error("lock flag at wrong time");
   chk_wake_time: assert property (wakeEvent && !coreRunning |=> wakeWait)
      else $error("wake time wrong");
   chk_sleep_stop: assert property (powerDownEnter && coreRunning |=> ##1 (!coreRunning && !systemClockEnable))
      else $error("clocks still enabled in sleep");
endmodule
bind system_clock_prescaler_pll_ctrl system_clock_props #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) chk (
   .mclk, .rst, .address, .writeData, .writeStrobe, .readStrobe, .readData,
   .clockSourceSelectFuses, .powerDownEnter, .wakeEvent, .systemClockEnable, .coreRunning,
   .externalClockSelected, .rcOscillatorTrim, .rcOscillatorRunning, .pllRunning,
   .pllFactorSelect, .pllLockedFlag, .watchdogTick
);
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        mclk, rst, writeStrobe, readStrobe, powerDownEnter, wakeEvent;
   logic [7:0]  address, writeData;
   logic [3:0]  clockSourceSelectFuses;
   logic        clockOutputFuse, divideByEightFuse;
   wire  [7:0]  readData, rcOscillatorTrim;
   wire         systemClockEnable, coreRunning, clockOutputPin, clockOutputEnable;
   wire         externalClockSelected, rcOscillatorRunning, pllRunning, pllFactorSelect;
   wire         pllLockedFlag, watchdogTick;
   wire  [9:0]  gap;
   wire  [15:0] pinRises;
   int          n_errors, n_compared;
   // fuses are static pins; short counts keep the run brief
   system_clock_prescaler_pll_ctrl #(.FAST_DELAY_CYCLES(20'h00014), .SLOW_DELAY_CYCLES(20'h00028),
      .PLL_LOCK_CYCLES(20'h0001E)) DUT (
      .mclk, .rst, .address, .writeData, .writeStrobe, .readStrobe, .readData,
      .clockSourceSelectFuses, .startupTimeFuses(2'h1), .clockOutputFuse,
      .divideByEightFuse, .factoryTrim(8'h5A), .powerDownEnter, .wakeEvent,
      .systemClockEnable, .coreRunning, .clockOutputPin, .clockOutputEnable,
      .externalClockSelected, .rcOscillatorTrim, .rcOscillatorRunning, .pllRunning,
      .pllFactorSelect, .pllLockedFlag, .watchdogTick);
   clock_consumer_model consumer (.mclk, .rst, .systemClockEnable, .clockOutputPin, .gap, .pinRises);
   // steady source: no cycle-to-cycle frequency step at all
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge mclk);
      writeStrobe <= 1'b0;
   endtask
   task rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge mclk);
      readStrobe <= 1'b0;
      #1;
      check(what, readData, exp);
   endtask
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task t_after_reset;
      int n;
      n = 0;
      while (!coreRunning && n < 100) begin
         @(posedge mclk);
         n++;
      end
      check("startup", n >= 33 && n <= 37, 1);
      check("ext_sel", externalClockSelected, 1);
      check("pin_override", clockOutputEnable, 1);
      check("pin_runs", pinRises >= 3, 1);
      rdc("trim_reset", 8'h66, 8'h5A);
      rdc("div_reset", 8'h61, 8'h03);
      rdc("pll_reset", 8'h49, 8'h00);
      rdc("unmapped", 8'h10, 8'h00);
      // after start-up the enables come every eight cycles, the divide-by-eight reset factor
      repeat (20) @(posedge mclk);
      check("gap_reset", gap, 8);
   endtask
   // codes 0 to 9, reserved code 9 dividing by 256; nothing else runs between the writes
   task t_divider_codes;
      for (int c = 0; c < 10; c++) begin
         wr(8'h61, 8'h80);
         wr(8'h61, c[7:0]);
         rdc("div_sel", 8'h61, c[7:0]);
         repeat (800) @(posedge mclk);
         check("gap", gap, 16'h0001 << ((c > 8) ? 8 : c));
      end
   endtask
   task t_unlock_guard;
      wr(8'h61, 8'h80);
      wr(8'h61, 8'h02);
      wr(8'h61, 8'h81);
      wr(8'h61, 8'h05);
      rdc("not_exact", 8'h61, 8'h02);
      wr(8'h61, 8'h80);
      rdc("ce_set", 8'h61, 8'h82);
      wr(8'h61, 8'h04);
      rdc("last_slot", 8'h61, 8'h04);
      wr(8'h61, 8'h80);
      wr(8'h61, 8'h80);
      @(posedge mclk);
      wr(8'h61, 8'h06);
      rdc("no_extend", 8'h61, 8'h04);
   endtask
   // no flash or eeprom write runs here, so even the top trim value is safe
   task t_trim;
      logic [7:0] v [3] = '{8'h7F, 8'h80, 8'h00};
      foreach (v[i]) begin
         wr(8'h66, v[i]);
         rdc("trim", 8'h66, v[i]);
         check("trim_port", rcOscillatorTrim, v[i]);
      end
   endtask
   task t_pll;
      wr(8'h49, 8'hFF);
      repeat (2) @(posedge mclk);
      check("pll_on", {pllRunning, rcOscillatorRunning, pllFactorSelect}, 3'b111);
      rdc("pll_unlocked", 8'h49, 8'h06);
      repeat (40) @(posedge mclk);
      rdc("pll_locked", 8'h49, 8'h07);
      wr(8'h49, 8'h02);
      rdc("pll_32", 8'h49, 8'h03);
   endtask
   task t_sleep;
      int n;
      n = 0;
      @(posedge mclk);
      powerDownEnter <= 1'b1;
      @(posedge mclk);
      powerDownEnter <= 1'b0;
      repeat (3) @(posedge mclk);
      check("asleep", {coreRunning, systemClockEnable}, 2'b00);
      @(posedge mclk);
      wakeEvent <= 1'b1;
      @(posedge mclk);
      wakeEvent <= 1'b0;
      while (!coreRunning && n < 20) begin
         @(posedge mclk);
         n++;
      end
      check("wake", n >= 5 && n <= 8, 1);
   endtask
   // second reset in mid-run with other fuses: pll source, no pin, no divide by eight
   task t_fuse_reset;
      @(posedge mclk);
      rst <= 1'b1;
      clockSourceSelectFuses <= 4'h3;
      clockOutputFuse <= 1'b0;
      divideByEightFuse <= 1'b0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      repeat (40) @(posedge mclk);
      check("ext_off", externalClockSelected, 0);
      check("pin_off", {clockOutputEnable, clockOutputPin}, 0);
      check("pll_src", pllRunning, 1);
      rdc("pll_src_read", 8'h49, 8'h03);
      rdc("div_fuse_off", 8'h61, 8'h00);
      check("gap_fuse_off", gap, 1);
   endtask
   initial begin
      {rst, writeStrobe, readStrobe, powerDownEnter, wakeEvent} = 5'b10000;
      {address, writeData, n_errors, n_compared} = 0;
      {clockSourceSelectFuses, clockOutputFuse, divideByEightFuse} = 6'h03;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_after_reset();
      t_divider_codes();
      t_unlock_guard();
      t_trim();
      t_pll();
      t_sleep();
      t_fuse_reset();
      tally_and_finish();
   end
   // cut a hang well beyond the expected run of about eight thousand three hundred cycles
   initial begin
      #(40000 * 100);
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
